// >>> rtl/watchdog_sleep_idle_control.sv
`timescale 1ns/1ns
`include "wdt_sleep_cfg.svh"

// Summary of operation
// - Fuse enables watchdog; erased fuse reads one
// - Enabled watchdog overflow resets device unless in Sleep or Idle
// - Time-out during Sleep wakes instead of resetting
// - Fuse clear lets soft enable bit control
// - Four-bit level field selects detect threshold
// - Enable bit powers detector; bandgap flag shows settled
// - Power-save instruction enters Sleep or Idle
// - Sleep gates CPU, peripheral clocks, stops oscillator unless low-power crystal is running
// - Sleep: monitor off, RC alive for watchdog
// - Interrupt, reset or time-out ends Sleep
// - Wake restarts previous clock source
// - Crystal waits start-up; crystal with PLL also waits lock, delays
// - Simple clock sources apply only power-on delay
// - Running low-power crystal: only power-on delay
// - Interrupt wake branches to handler, sets sleep flag
// - Clock dead after delays: trap or suspend
// - Resets wake Sleep; non-power-on resets flag sleep
// - Watchdog wake from Sleep sets both flags
// - Idle stops CPU clock only; RC kept
// - Idle wake immediate, resumes next or handler
// - Idle flag from non-power-on resets, interrupt, watchdog wake

module watchdog_sleep_idle_control #(
  parameter int unsigned PWRT_MAX_CYC = `PWRT_64MS_CYC
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [15:0]             reg_addr_i,
  input  wire logic                    reg_we_i,
  input  wire wdt_sleep_pkg::reg_word_t reg_wdata_i,
  output wdt_sleep_pkg::reg_word_t     reg_rdata_o,
  input  wire logic [23:0]             tbl_addr_i,
  output wdt_sleep_pkg::cfg_word_t     tbl_rdata_o,
  input  wire logic                    prog_we_i,
  input  wire logic                    chip_erase_i,
  input  wire wdt_sleep_pkg::cfg_word_t prog_data_i,
  input  wire logic                    power_save_instr_i,
  input  wire logic                    power_save_idle_i,
  input  wire logic                    watchdog_clear_instr_i,
  input  wire logic                    soft_reset_i,
  input  wire logic                    irq_wake_i,
  input  wire logic                    master_clear_pin_n_i,
  input  wire logic                    power_on_event_i,
  input  wire logic                    brown_out_event_i,
  input  wire logic                    osc_stable_i,
  input  wire logic                    pll_locked_i,
  input  wire logic                    low_power_rc_clock_i,
  input  wire wdt_sleep_pkg::osc_sel_t current_osc_select_i,
  input  wire logic                    src_is_crystal_i,
  input  wire logic                    src_uses_pll_i,
  input  wire logic                    src_is_low_power_crystal_i,
  input  wire logic                    low_power_crystal_on_i,
  output logic                         cpu_clk_en_o,
  output logic                         periph_clk_en_o,
  output logic                         osc_run_o,
  output logic                         low_power_rc_run_o,
  output logic                         clock_fail_monitor_on_o,
  output logic                         lvd_on_o,
  output logic [3:0]                   lvd_level_select_o,
  output wdt_sleep_pkg::osc_sel_t      restart_osc_o,
  output logic                         sys_reset_o,
  output logic                         isr_branch_o,
  output logic                         resume_next_o,
  output logic                         clk_fail_trap_o,
  output logic                         sleep_active_o,
  output logic                         idle_active_o
);
  import wdt_sleep_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  logic            rc_prev_reg;

  assign pin_raw = {low_power_rc_clock_i, pll_locked_i, osc_stable_i,
                    brown_out_event_i, power_on_event_i,
                    ~master_clear_pin_n_i};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_s1_reg  <= '0;
      pin_s2_reg  <= '0;
      rc_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg  <= pin_raw;
      pin_s2_reg  <= pin_s1_reg;
      rc_prev_reg <= pin_s2_reg[5];
    end
  end

  wire master_clear = pin_s2_reg[0];
  wire power_on_rst = pin_s2_reg[1];
  wire brown_out    = pin_s2_reg[2];
  wire osc_ready    = pin_s2_reg[3];
  wire pll_ready    = pin_s2_reg[4];
  wire rc_tick      = pin_s2_reg[5] && !rc_prev_reg;

  //////////////////////////////////////////////////////////////////////////
  // Configuration words: altered only by logic reset, programming or erase
  cfg_word_t cfg_osc_reg;
  cfg_word_t cfg_wdt_reg;
  cfg_word_t cfg_bo_reg;
  cfg_word_t cfg_guard_reg;
  cfg_word_t cfg_dbg_reg;

  // Logic reset stands in for first power-up of an erased part
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || chip_erase_i) begin
      cfg_osc_reg   <= `CFG_ERASED;
      cfg_wdt_reg   <= `CFG_ERASED;
      cfg_bo_reg    <= `CFG_ERASED;
      cfg_guard_reg <= `CFG_ERASED;
      cfg_dbg_reg   <= `CFG_ERASED;
    end else if (prog_we_i) begin
      unique case (tbl_addr_i)
        `CFG_OSC_ADDR:      cfg_osc_reg   <= prog_data_i;
        `CFG_WDT_ADDR:      cfg_wdt_reg   <= prog_data_i;
        `CFG_BROWNOUT_ADDR: cfg_bo_reg    <= prog_data_i;
        `CFG_GUARD_ADDR:    cfg_guard_reg <= prog_data_i;
        `CFG_DEBUG_ADDR:    cfg_dbg_reg   <= prog_data_i;
        default:            ;
      endcase
    end
  end

  wire [1:0] cksm      = cfg_osc_reg[`CFG_CKSM_MSB:`CFG_CKSM_LSB];
  wire       clksw_en  = !cksm[1];
  wire       cfm_en    = (cksm == 2'b00);
  wire [1:0] pwrt_sel  = cfg_bo_reg[`CFG_PWRT_MSB:`CFG_PWRT_LSB];
  wire       fuse_wdt  = cfg_wdt_reg[`CFG_WDT_EN_BIT];

  cfg_word_t tbl_next;
  cfg_word_t tbl_reg;
  assign tbl_next = (tbl_addr_i == `CFG_OSC_ADDR)      ? cfg_osc_reg :
                    (tbl_addr_i == `CFG_WDT_ADDR)      ? cfg_wdt_reg :
                    (tbl_addr_i == `CFG_BROWNOUT_ADDR) ? cfg_bo_reg :
                    (tbl_addr_i == `CFG_GUARD_ADDR)    ? cfg_guard_reg :
                    (tbl_addr_i == `CFG_DEBUG_ADDR)    ? cfg_dbg_reg :
                    24'h000000;

  //////////////////////////////////////////////////////////////////////////
  // State and reset-control register
  pwr_state_e state_reg;
  pwr_state_e state_next;
  reg_word_t  rst_reg;
  reg_word_t  rst_next;
  reg_word_t  rdata_reg;
  delay_cnt_t dly_reg;
  delay_cnt_t dly_next;
  logic [10:0] bg_reg;
  logic        trap_reg;
  logic        isr_reg;
  logic        resume_reg;
  logic        sysrst_reg;
  logic        wake_irq_reg;
  logic        wdt_timeout;

  wire soft_wdt  = rst_reg[`RST_SOFT_WDT_BIT];
  wire wdt_en    = fuse_wdt || soft_wdt;
  wire lvd_en    = rst_reg[`RST_LVD_EN_BIT];
  wire in_sleep  = (state_reg == ST_SLEEP);
  wire in_idle   = (state_reg == ST_IDLE);
  wire any_ext   = power_on_rst || brown_out || master_clear;
  wire wdt_reset = wdt_timeout && !in_sleep;
  wire wdt_wake  = wdt_timeout && (in_sleep || in_idle);
  wire any_reset = any_ext || soft_reset_i || (wdt_reset && !in_idle);
  wire irq_sleep = irq_wake_i && in_sleep;
  wire irq_idle  = irq_wake_i && in_idle;
  wire reg_hit   = (reg_addr_i == `RSTCTL_ADDR);
  wire reg_wr    = reg_we_i && reg_hit;
  wire bg_done   = (bg_reg == 11'(`BANDGAP_CYC));
  wire enter_ps  = power_save_instr_i && (state_reg == ST_RUN);
  wire clk_alive = osc_ready && (!src_uses_pll_i || pll_ready);

  wdt_counter u_wdt (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (rc_tick),
    .enable_i  (wdt_en),
    .clear_i   (watchdog_clear_instr_i),
    .timeout_o (wdt_timeout)
  );

  //////////////////////////////////////////////////////////////////////////
  // Wake delay selection
  delay_cnt_t pwrt_cyc;
  delay_cnt_t wake_dly;
  wire        fast_wake;

  assign pwrt_cyc = (pwrt_sel == 2'b00) ? 21'h000000 :
                    (pwrt_sel == 2'b01) ? 21'(PWRT_MAX_CYC / 16) :
                    (pwrt_sel == 2'b10) ? 21'(PWRT_MAX_CYC / 4) :
                    21'(PWRT_MAX_CYC);
  // Running low-power crystal or non-crystal source: power-on delay only
  assign fast_wake = !src_is_crystal_i ||
                     (src_is_low_power_crystal_i &&
                      low_power_crystal_on_i);
  assign wake_dly  = fast_wake ? 21'(`POWER_ON_DELAY_CYC) :
                     21'(`POWER_ON_DELAY_CYC) + pwrt_cyc +
                     (src_uses_pll_i ? 21'(`PLL_LOCK_DELAY_CYC) : 21'h000000);

  //////////////////////////////////////////////////////////////////////////
  // Power state machine
  always_comb begin
    state_next = state_reg;
    dly_next   = dly_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (enter_ps) begin
          state_next = power_save_idle_i ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_IDLE: begin
        if (any_reset || irq_wake_i || wdt_timeout) begin
          state_next = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (any_reset || irq_wake_i || wdt_timeout) begin
          state_next = ST_WAKE_DLY;
          dly_next   = wake_dly;
        end
      end
      ST_WAKE_DLY: begin
        if (dly_reg > 21'h000001) begin
          dly_next = dly_reg - 21'h000001;
        end else if (fast_wake || clk_alive || cfm_en) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_WAIT_CLK;
        end
      end
      ST_WAIT_CLK: begin
        if (clk_alive) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  wire wake_done  = (state_reg == ST_WAKE_DLY) && (state_next == ST_RUN);
  wire trap_now   = wake_done && !fast_wake && !clk_alive;
  wire clk_resume = wake_done || ((state_reg == ST_WAIT_CLK) && clk_alive);

  //////////////////////////////////////////////////////////////////////////
  // Reset-control register; hardware sets win over software writes
  always_comb begin
    rst_next = rst_reg;
    if (reg_wr) begin
      rst_next = (reg_wdata_i & `RSTCTL_WMASK) |
                 (rst_reg & ~`RSTCTL_WMASK);
    end
    rst_next[`RST_BANDGAP_BIT] = lvd_en && bg_done;
    rst_next[15:14] = 2'b00;
    if (power_on_rst) begin
      rst_next[7:0] = 8'h03;
      rst_next[`RST_SOFT_WDT_BIT] = 1'b0;
    end else begin
      if (brown_out) begin
        rst_next[`RST_BROWNOUT_BIT] = 1'b1;
        rst_next[`RST_POWERON_BIT]  = 1'b0;
      end
      if (master_clear) begin
        rst_next[`RST_EXTRST_BIT] = 1'b1;
        rst_next[`RST_WDT_TO_BIT] = 1'b0;
      end
      if (soft_reset_i) begin
        rst_next[`RST_SOFTRST_BIT] = 1'b1;
        rst_next[`RST_EXTRST_BIT]  = master_clear;
        rst_next[`RST_WDT_TO_BIT]  = 1'b0;
      end
      if (any_reset && (in_sleep || state_reg == ST_WAKE_DLY)) begin
        rst_next[`RST_SLEEP_BIT] = 1'b1;
      end
      if (any_reset && in_idle) begin
        rst_next[`RST_IDLE_BIT] = 1'b1;
      end
      if (irq_sleep || wdt_wake && in_sleep) begin
        rst_next[`RST_SLEEP_BIT] = 1'b1;
      end
      if (irq_idle || wdt_wake && in_idle) begin
        rst_next[`RST_IDLE_BIT] = 1'b1;
      end
      if (wdt_timeout) begin
        rst_next[`RST_WDT_TO_BIT] = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_RUN;
      dly_reg   <= '0;
      rst_reg   <= `RSTCTL_RESET;
      rdata_reg <= '0;
      tbl_reg   <= '0;
    end else begin
      state_reg <= state_next;
      dly_reg   <= dly_next;
      rst_reg   <= rst_next;
      rdata_reg <= reg_hit ? rst_reg : 16'h0000;
      tbl_reg   <= tbl_next;
    end
  end

  // Bandgap settle timer restarts whenever the detector is switched off
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !lvd_en) begin
      bg_reg <= '0;
    end else if (!bg_done) begin
      bg_reg <= bg_reg + 11'h001;
    end
  end

  // Interrupt cause is held across the Sleep wake delay
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wake_irq_reg <= 1'b0;
    end else if (irq_sleep && !any_reset) begin
      wake_irq_reg <= 1'b1;
    end else if (clk_resume || any_reset) begin
      wake_irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      trap_reg   <= 1'b0;
      isr_reg    <= 1'b0;
      resume_reg <= 1'b0;
      sysrst_reg <= 1'b0;
    end else begin
      trap_reg   <= trap_now && cfm_en;
      sysrst_reg <= any_reset;
      isr_reg    <= !any_reset && (irq_idle ||
                    (clk_resume && wake_irq_reg));
      resume_reg <= !any_reset && ((in_idle && wdt_timeout && !irq_wake_i) ||
                    (clk_resume && !wake_irq_reg));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock gating and power outputs
  wire stopped = in_sleep || (state_reg == ST_WAKE_DLY) ||
                 (state_reg == ST_WAIT_CLK);

  assign cpu_clk_en_o            = !stopped && !in_idle;
  assign periph_clk_en_o         = !stopped;
  assign osc_run_o               = !in_sleep ||
                                   (src_is_low_power_crystal_i &&
                                    low_power_crystal_on_i);
  assign low_power_rc_run_o      = wdt_en || (cfm_en && !in_sleep);
  assign clock_fail_monitor_on_o = cfm_en && !stopped;
  assign lvd_on_o                = lvd_en;
  assign lvd_level_select_o      = rst_reg[`RST_LVL_MSB:`RST_LVL_LSB];
  assign restart_osc_o           = clksw_en ? current_osc_select_i :
                                   cfg_osc_reg[`CFG_OSCSEL_MSB:
                                               `CFG_OSCSEL_LSB];
  assign sys_reset_o             = sysrst_reg;
  assign isr_branch_o            = isr_reg;
  assign resume_next_o           = resume_reg;
  assign clk_fail_trap_o         = trap_reg;
  assign sleep_active_o          = stopped;
  assign idle_active_o           = in_idle;
  assign reg_rdata_o             = rdata_reg;
  assign tbl_rdata_o             = tbl_reg;

endmodule

// >>> rtl/wdt_sleep_cfg.svh
`ifndef WDT_SLEEP_CFG_SVH
`define WDT_SLEEP_CFG_SVH

// Register addresses
`define RSTCTL_ADDR        16'h0740
`define CFG_OSC_ADDR       24'hf80000
`define CFG_WDT_ADDR       24'hf80002
`define CFG_BROWNOUT_ADDR  24'hf80004
`define CFG_GUARD_ADDR     24'hf8000a
`define CFG_DEBUG_ADDR     24'hf8000c

// Reset-control register fields
`define RST_POWERON_BIT    0
`define RST_BROWNOUT_BIT   1
`define RST_IDLE_BIT       2
`define RST_SLEEP_BIT      3
`define RST_WDT_TO_BIT     4
`define RST_SOFT_WDT_BIT   5
`define RST_SOFTRST_BIT    6
`define RST_EXTRST_BIT     7
`define RST_LVL_LSB        8
`define RST_LVL_MSB        11
`define RST_LVD_EN_BIT     12
`define RST_BANDGAP_BIT    13
`define RSTCTL_RESET       16'h0003
`define RSTCTL_WMASK       16'h1fff

// Configuration word fields
`define CFG_WDT_EN_BIT     15
`define CFG_CKSM_MSB       15
`define CFG_CKSM_LSB       14
`define CFG_OSCSEL_MSB     10
`define CFG_OSCSEL_LSB     8
`define CFG_PWRT_MSB       1
`define CFG_PWRT_LSB       0
`define CFG_ERASED         24'h00ffff

// Timing
`define CLK_PERIOD_NS      50
`define POWER_ON_DELAY_NS            10000
`define POWER_ON_DELAY_CYC           ((`POWER_ON_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_LOCK_DELAY_NS           20000
`define PLL_LOCK_DELAY_CYC          ((`PLL_LOCK_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_TIMER_DELAY_MAX_MS       64
`define PWRT_64MS_CYC      ((`POWERUP_TIMER_DELAY_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define BANDGAP_NS         20000
`define BANDGAP_CYC        ((`BANDGAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDT_PRESCALE       32
`define WDT_COUNT_MAX      16'h00ff

`endif

// >>> rtl/wdt_sleep_pkg.sv
package wdt_sleep_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE,
    ST_SLEEP,
    ST_WAKE_DLY,
    ST_WAIT_CLK
  } pwr_state_e;

  typedef logic [15:0] reg_word_t;
  typedef logic [23:0] cfg_word_t;
  typedef logic [2:0]  osc_sel_t;
  typedef logic [20:0] delay_cnt_t;

endpackage

// >>> rtl/wdt_counter.sv
`timescale 1ns/1ns
`include "wdt_sleep_cfg.svh"

module wdt_counter (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic tick_i,
  input  wire logic enable_i,
  input  wire logic clear_i,
  output logic      timeout_o
);

  logic [7:0]  pre_reg;
  logic [7:0]  pre_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        pre_wrap;
  logic        overflow;
  logic        timeout_reg;

  assign pre_wrap = tick_i && (pre_reg == 8'(`WDT_PRESCALE - 1));
  assign overflow = enable_i && pre_wrap && (cnt_reg == `WDT_COUNT_MAX);
  assign pre_next = (clear_i || !enable_i) ? 8'h00 :
                    pre_wrap ? 8'h00 :
                    tick_i   ? pre_reg + 8'h01 : pre_reg;
  // Restart after overflow so a waking time-out does not repeat at once
  assign cnt_next = (clear_i || !enable_i || overflow) ? 16'h0000 :
                    pre_wrap ? cnt_reg + 16'h0001 : cnt_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pre_reg     <= 8'h00;
      cnt_reg     <= 16'h0000;
      timeout_reg <= 1'b0;
    end else begin
      pre_reg     <= pre_next;
      cnt_reg     <= cnt_next;
      timeout_reg <= overflow && !clear_i;
    end
  end

  assign timeout_o = timeout_reg;

endmodule

// >>> test/wdt_sleep_assertions.sv
`timescale 1ns/1ns
module wdt_sleep_assertions (
  input wire logic                     sys_clk_i,
  input wire logic                     rst_n_i,
  input wire logic [15:0]              reg_addr_i,
  input wire logic                     reg_we_i,
  input wire wdt_sleep_pkg::reg_word_t reg_wdata_i,
  input wire wdt_sleep_pkg::reg_word_t reg_rdata_o,
  input wire logic                     power_save_instr_i,
  input wire logic                     power_save_idle_i,
  input wire logic                     irq_wake_i,
  input wire logic                     master_clear_pin_n_i,
  input wire logic                     soft_reset_i,
  input wire logic                     brown_out_event_i,
  input wire logic                     power_on_event_i,
  input wire logic                     src_is_crystal_i,
  input wire logic                     src_uses_pll_i,
  input wire logic                     low_power_crystal_on_i,
  input wire logic                     cpu_clk_en_o,
  input wire logic                     periph_clk_en_o,
  input wire logic                     osc_run_o,
  input wire logic                     clock_fail_monitor_on_o,
  input wire logic                     lvd_on_o,
  input wire logic [3:0]               lvd_level_select_o,
  input wire logic                     sys_reset_o,
  input wire logic                     isr_branch_o,
  input wire logic                     sleep_active_o,
  input wire logic                     idle_active_o
);
  import wdt_sleep_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // No reset source seen for a while, so the sync chains are quiet
  sequence quiet_s;
    master_clear_pin_n_i && !power_on_event_i && !brown_out_event_i
      && !soft_reset_i;
  endsequence
  sequence fast_irq_s;
    sleep_active_o && $rose(irq_wake_i) && !src_is_crystal_i
      && !src_uses_pll_i;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_enter_save_state: assert property (
    power_save_instr_i && cpu_clk_en_o && !sys_reset_o && !irq_wake_i |=>
    ($past(power_save_idle_i) ? idle_active_o
      : sleep_active_o && (low_power_crystal_on_i || !osc_run_o)))
    else $error("power-save entry state wrong");
  a_sleep_clk_gate: assert property (
    sleep_active_o |-> !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clock enabled in sleep");
  a_sleep_monitor_off: assert property (
    sleep_active_o |-> !clock_fail_monitor_on_o)
    else $error("clock monitor on in sleep");
  a_idle_clk_gate: assert property (
    idle_active_o |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("idle clock gating wrong");
  a_idle_irq_wake: assert property (
    idle_active_o && irq_wake_i |=> cpu_clk_en_o && isr_branch_o)
    else $error("idle interrupt wake late");
  a_fast_wake_delay: assert property (
    fast_irq_s |-> ##1 !cpu_clk_en_o [*8] ##[180:205] cpu_clk_en_o)
    else $error("fast wake delay wrong");
  a_isr_after_wake: assert property (
    $rose(cpu_clk_en_o) && $past(sleep_active_o) && irq_wake_i
      && !src_is_crystal_i |-> isr_branch_o)
    else $error("no handler branch after sleep wake");
  a_sleep_no_reset: assert property (
    quiet_s [*5] ##0 sleep_active_o |=> !sys_reset_o)
    else $error("reset raised in sleep without cause");
  a_lvd_from_reg: assert property (
    reg_we_i && reg_addr_i == 16'h0740 |=>
    lvd_level_select_o == $past(reg_wdata_i[11:8])
      && lvd_on_o == $past(reg_wdata_i[12]))
    else $error("detector controls not taken from write");
  a_read_after_write: assert property (
    reg_we_i && reg_addr_i == 16'h0740 ##1 reg_addr_i == 16'h0740 |=>
    reg_rdata_o[12:8] == $past(reg_wdata_i[12:8], 2))
    else $error("written detector bits not read back");
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  import wdt_sleep_pkg::*;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, reg_we_i = 1'b0, prog_we_i = 1'b0;
  logic chip_erase_i = 1'b0, power_save_instr_i = 1'b0;
  logic power_save_idle_i = 1'b0, watchdog_clear_instr_i = 1'b0;
  logic soft_reset_i = 1'b0, irq_wake_i = 1'b0, master_clear_pin_n_i = 1'b1;
  logic power_on_event_i = 1'b0, brown_out_event_i = 1'b0;
  logic osc_stable_i = 1'b1, pll_locked_i = 1'b0, low_power_rc_clock_i = 1'b0;
  logic src_is_crystal_i = 1'b0, src_uses_pll_i = 1'b0;
  logic src_is_low_power_crystal_i = 1'b0, low_power_crystal_on_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  reg_word_t   reg_wdata_i = 16'h0000, reg_rdata_o, r;
  logic [23:0] tbl_addr_i = 24'h000000;
  cfg_word_t   prog_data_i = 24'h000000, tbl_rdata_o, c;
  osc_sel_t    current_osc_select_i = 3'h5, restart_osc_o;
  logic        cpu_clk_en_o, periph_clk_en_o, osc_run_o, low_power_rc_run_o;
  logic        clock_fail_monitor_on_o, lvd_on_o, sys_reset_o, isr_branch_o;
  logic        resume_next_o, clk_fail_trap_o, sleep_active_o, idle_active_o;
  logic [3:0]  lvd_level_select_o;
  logic        rc_on = 1'b0;
  int          n_tests = 0, n_mismatch = 0, n_cyc = 0, n_rst = 0, n, nr;

  // Short power-up timer keeps the crystal wake case brief
  watchdog_sleep_idle_control #(.PWRT_MAX_CYC(64)) uut (.*);

  always #25 sys_clk_i = ~sys_clk_i;
  // RC clock slow enough for the 2FF sync to follow: one tick per 4 cycles
  always #100 if (rc_on) low_power_rc_clock_i = ~low_power_rc_clock_i;
  always @(posedge sys_clk_i) begin
    n_cyc++;
    if (sys_reset_o === 1'b1) n_rst++;
    if (n_cyc == 90000) begin
      n_mismatch++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [15:0] a, input reg_word_t d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_we_i = 1'b1;
    @(negedge sys_clk_i);
    reg_we_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output reg_word_t d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask
  task automatic trd(input logic [23:0] a, output cfg_word_t d);
    @(negedge sys_clk_i);
    tbl_addr_i = a;
    @(negedge sys_clk_i);
    d = tbl_rdata_o;
  endtask
  task automatic prog(input logic [23:0] a, input cfg_word_t d);
    @(negedge sys_clk_i);
    tbl_addr_i = a;
    prog_data_i = d;
    prog_we_i = 1'b1;
    @(negedge sys_clk_i);
    prog_we_i = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk_i);
    s = 1'b1;
    @(negedge sys_clk_i);
    s = 1'b0;
  endtask
  task automatic wait_hi(ref logic s, input int lim, output int k);
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(negedge sys_clk_i);
      k++;
    end
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    rst_n_i = 1'b1;
    cyc(3);
    rd(16'h0740, r); `CHK("reset_control_reg_rst", 16'h0003, r)
    trd(24'hf80002, c); `CHK("wdt_fuse", 24'h00ffff, c)
    rd(16'h0742, r); `CHK("unmapped", 16'h0000, r)
    `CHK("osc_fixed", 3'h7, restart_osc_o)
    fin("reset");
    wr(16'h0740, 16'h3a03);
    rd(16'h0740, r); `CHK("lvd_wr", 16'h1a03, r)
    `CHK("lvd_on", 1'b1, lvd_on_o)
    `CHK("lvd_lvl", 4'ha, lvd_level_select_o)
    cyc(410);
    rd(16'h0740, r); `CHK("bandgap", 16'h3a03, r)
    wr(16'h0740, 16'h0000);
    fin("detector");
    prog(24'hf80002, 24'h000000);
    trd(24'hf80002, c); `CHK("fuse_prog", 24'h000000, c)
    `CHK("rc_off", 1'b0, low_power_rc_run_o)
    wr(16'h0740, 16'h0020);
    cyc(1); `CHK("rc_soft", 1'b1, low_power_rc_run_o)
    wr(16'h0740, 16'h0000);
    pulse(chip_erase_i);
    trd(24'hf80002, c); `CHK("erase", 24'h00ffff, c)
    fin("fuse");
    power_save_idle_i = 1'b1;
    pulse(power_save_instr_i);
    `CHK("idle", 1'b1, idle_active_o)
    `CHK("idle_cpu", 1'b0, cpu_clk_en_o)
    `CHK("idle_per", 1'b1, periph_clk_en_o)
    irq_wake_i = 1'b1;
    cyc(1); `CHK("idle_isr", 1'b1, cpu_clk_en_o & isr_branch_o)
    irq_wake_i = 1'b0;
    rd(16'h0740, r); `CHK("idle_flag", 16'h0004, r & 16'h00ff)
    fin("idle");
    wr(16'h0740, 16'h0000);
    power_save_idle_i = 1'b0;
    pulse(power_save_instr_i);
    `CHK("sleep", 1'b1, sleep_active_o)
    `CHK("sleep_per", 1'b0, periph_clk_en_o)
    `CHK("sleep_osc", 1'b0, osc_run_o)
    `CHK("sleep_mon", 1'b0, clock_fail_monitor_on_o)
    irq_wake_i = 1'b1;
    wait_hi(cpu_clk_en_o, 400, n);
    `CHK("wake_dly", 1'b1, n >= 195 && n <= 210)
    `CHK("isr", 1'b1, isr_branch_o)
    irq_wake_i = 1'b0;
    rd(16'h0740, r); `CHK("sleep_flag", 16'h0008, r & 16'h00ff)
    cyc(20);
    rd(16'h0740, r); `CHK("sticky", 16'h0008, r & 16'h00ff)
    wr(16'h0740, 16'h0000);
    rd(16'h0740, r); `CHK("cleared", 16'h0000, r & 16'h00ff)
    fin("sleep");
    pulse(watchdog_clear_instr_i);
    pulse(power_save_instr_i);
    nr = n_rst;
    rc_on = 1'b1;
    wait_hi(resume_next_o, 40000, n);
    rc_on = 1'b0;
    `CHK("wdt_wake", 1'b1, resume_next_o)
    `CHK("no_reset", nr, n_rst)
    rd(16'h0740, r); `CHK("wdt_flags", 16'h0018, r & 16'h00ff)
    fin("watchdog wake");
    pulse(watchdog_clear_instr_i);
    nr = n_rst;
    rc_on = 1'b1;
    wait_hi(sys_reset_o, 40000, n);
    rc_on = 1'b0;
    cyc(4); `CHK("wdt_reset", 1'b1, n_rst > nr)
    rd(16'h0740, r); `CHK("wdt_to", 16'h0010, r & 16'h0010)
    wr(16'h0740, 16'h0000);
    pulse(soft_reset_i);
    cyc(4);
    rd(16'h0740, r); `CHK("soft_rst", 16'h0040, r & 16'h004c)
    brown_out_event_i = 1'b1;
    cyc(4);
    brown_out_event_i = 1'b0;
    cyc(4);
    rd(16'h0740, r); `CHK("brown_out", 16'h0002, r & 16'h0003)
    fin("resets");
    wr(16'h0740, 16'h0000);
    pulse(power_save_instr_i);
    master_clear_pin_n_i = 1'b0;
    cyc(4);
    master_clear_pin_n_i = 1'b1;
    wait_hi(cpu_clk_en_o, 400, n);
    `CHK("master_clear_pin_wake", 1'b0, sleep_active_o)
    rd(16'h0740, r); `CHK("master_clear_pin_flags", 16'h0088, r & 16'h00ff)
    fin("master clear");
    power_on_event_i = 1'b1;
    cyc(4);
    power_on_event_i = 1'b0;
    cyc(4);
    rd(16'h0740, r); `CHK("por_flags", 16'h0003, r & 16'h00ff)
    prog(24'hf80000, 24'h000000);
    cyc(1); `CHK("osc_switch", 3'h5, restart_osc_o)
    `CHK("mon_run", 1'b1, clock_fail_monitor_on_o)
    src_is_crystal_i = 1'b1;
    osc_stable_i = 1'b0;
    pulse(power_save_instr_i);
    irq_wake_i = 1'b1;
    wait_hi(clk_fail_trap_o, 3000, n);
    `CHK("trap", 1'b1, clk_fail_trap_o)
    `CHK("trap_late", 1'b1, n >= 200)
    irq_wake_i = 1'b0;
    fin("clock fail");
    test_done();
  end
endmodule

bind watchdog_sleep_idle_control wdt_sleep_assertions chk (.*);
